// file: verilog/flash_link_cfg.svh
`ifndef FLASH_LINK_CFG_SVH
`define FLASH_LINK_CFG_SVH

// =====================================================================
// Lane selection codes
`define LANE_SINGLE      2'h0
`define LANE_DUAL        2'h1
`define LANE_QUAD        2'h2

// =====================================================================
// Pin arrangement codes
`define PINS_THREE       2'h0
`define PINS_FOUR        2'h1
`define PINS_SIX         2'h2

// =====================================================================
// Link timing and pin positions
`define DIV_ZERO_PER_M1  1
`define TAIL_LAST        2'h1
`define OUT_PIN          1
`define OUT_PIN_OE       4'h2
`define PINS_OFF         4'h0

`endif

// file: verilog/flash_link_pkg.sv
package flash_link_pkg;

    // =================================================================
    // Frame sequencer states
    typedef enum logic [3:0] {
        st_idle  = 4'b0001,
        st_lead  = 4'b0010,
        st_shift = 4'b0100,
        st_tail  = 4'b1000
    } link_state_t;

endpackage

// file: verilog/quad_spi_flash_read_master.sv
`timescale 1ns/1ps
`include "flash_link_cfg.svh"
// Summary of operation
// (RQ1) Always master: drives clock and select
// (RQ2) Reads over one, two or four lines
// (RQ3) Word length 1 to 128 bits
// (RQ4) 1 to 4096 words under one select
// (RQ5) Separately enabled word and frame interrupts
// (RQ6) Select-to-data delay of 0 to 3 periods
// (RQ7) Three, four or six pin arrangement
// (RQ8) Divider sets period and high/low split
// (RQ9) Software should prefer zero or odd divider
// (RQ10) Clock idles low, phase zero
// (RQ11) Input sampled on falling clock edges
// (RQ12) Select leads first falling edge by delay+1
// (RQ13) Select releases two periods after last fall
// (RQ14) Output changes on falls, first bit early
// (RQ15) Output pin driven from select active edge
// (RQ16) Final input bit sampled one period late
// (RQ17) Select active low for whole frame
// (RQ18) Sticky flags, interrupt is OR of enabled
module quad_spi_flash_read_master
    import flash_link_pkg::*;
#(
    parameter int WORD_W = 128,
    parameter int CNT_W  = 12,
    parameter int DIV_W  = 8
) (
    // Clock and reset
    input  wire logic                       clk_sys_in,
    input  wire logic                       reset_in,
    // Transfer setup
    input  wire logic                       start_in,
    input  wire logic [1:0]                 lane_mode_in,
    input  wire logic [1:0]                 pin_mode_in,
    input  wire logic [1:0]                 cs_to_clock_delay_field_in,
    input  wire logic [DIV_W-1:0]           serial_clock_divide_ratio_in,
    input  wire logic [$clog2(WORD_W)-1:0]  word_len_m1_in,
    input  wire logic [CNT_W-1:0]           word_count_m1_in,
    input  wire logic [WORD_W-1:0]          tx_word_in,
    // Interrupt control
    input  wire logic                       word_irq_en_in,
    input  wire logic                       frame_irq_en_in,
    input  wire logic                       word_flag_clr_in,
    input  wire logic                       frame_flag_clr_in,
    // Link pins
    input  wire logic [3:0]                 data_pin_in,
    output logic                            sclk_out,
    output logic                            cs_n_out,
    output logic [3:0]                      data_pin_out,
    output logic [3:0]                      data_pin_oe_out,
    // Status
    output logic                            busy_out,
    output logic [WORD_W-1:0]               rx_word_out,
    output logic                            word_valid_out,
    output logic                            frame_done_out,
    output logic                            word_flag_out,
    output logic                            frame_flag_out,
    output logic                            irq_out
);
    localparam int LEN_W = $clog2(WORD_W);
    typedef struct packed {
        link_state_t        fsm;
        logic [3:0]         sync1;
        logic [3:0]         sync2;
        logic [DIV_W:0]     ph;
        logic [1:0]         lead;
        logic [1:0]         tail;
        logic [LEN_W-1:0]   beat;
        logic [CNT_W-1:0]   word;
        logic [WORD_W-1:0]  tx_sh;
        logic [WORD_W-1:0]  rx_sh;
        logic [WORD_W-1:0]  rx_word;
        logic [1:0]         lanes;
        logic [1:0]         pins;
        logic [1:0]         dly;
        logic [DIV_W-1:0]   div;
        logic [LEN_W-1:0]   len_m1;
        logic [CNT_W-1:0]   cnt_m1;
        logic               sclk;
        logic               cs_n;
        logic               busy;
        logic               word_valid;
        logic               frame_done;
        logic               word_flag;
        logic               frame_flag;
        logic               irq;
        logic [3:0]         d_o;
        logic [3:0]         d_oe;
    } st_t;
    st_t s_r;
    st_t s_nxt;
    // =================================================================
    // Divider arithmetic: period P = div+1, or two ticks when div is zero
    function automatic logic [DIV_W:0] per_m1(input logic [DIV_W-1:0] div);
        per_m1 = (div == '0) ? (DIV_W+1)'(`DIV_ZERO_PER_M1) : {1'b0, div};
    endfunction
    // Low phase takes the larger half, so high is floor(P/2)
    function automatic logic [DIV_W:0] low_len(input logic [DIV_W-1:0] div);
        logic [DIV_W:0] p;
        p       = per_m1(div) + (DIV_W+1)'(1);
        low_len = p - (p >> 1);
    endfunction
    function automatic logic [WORD_W-1:0] rx_shift(input logic [WORD_W-1:0] rx, input logic [3:0] d,
                                                   input logic [1:0] lanes, input logic [1:0] pins);
        case (lanes)
            `LANE_QUAD: rx_shift = {rx[WORD_W-5:0], d};
            `LANE_DUAL: rx_shift = {rx[WORD_W-3:0], d[1:0]};
            default:    rx_shift = {rx[WORD_W-2:0], (pins == `PINS_THREE) ? d[`OUT_PIN] : d[0]};
        endcase
    endfunction

    // =================================================================
    // Next-state logic
    logic              period_end;
    logic              clk_per;
    logic              fe;
    logic              last_beat;
    logic              last_word;
    logic              word_done;
    logic              frame_end;
    logic              n_clk_per;
    logic [LEN_W-1:0]  beats_m1;
    logic [LEN_W-1:0]  tx_align;
    logic [WORD_W-1:0] rx_next;
    logic [1:0]        eff_lanes;
    always_comb begin
        s_nxt            = s_r;
        s_nxt.sync1      = data_pin_in;
        s_nxt.sync2      = s_r.sync1;
        word_done        = 1'b0;
        frame_end        = 1'b0;
        period_end       = (s_r.ph == per_m1(s_r.div));
        clk_per          = (s_r.fsm == st_lead && s_r.lead == s_r.dly) || s_r.fsm == st_shift;
        fe               = clk_per && period_end;
        case (s_r.lanes)
            `LANE_QUAD: beats_m1 = s_r.len_m1 >> 2;
            `LANE_DUAL: beats_m1 = s_r.len_m1 >> 1;
            default:    beats_m1 = s_r.len_m1;
        endcase
        last_beat = (s_r.beat == beats_m1);
        last_word = (s_r.word == s_r.cnt_m1);
        tx_align  = LEN_W'(WORD_W - 1) - s_r.len_m1;
        rx_next   = rx_shift(s_r.rx_sh, s_r.sync2, s_r.lanes, s_r.pins); // RQ11 RQ2
        // Unused lane code 3 behaves as single lane
        eff_lanes = (pin_mode_in == `PINS_SIX && lane_mode_in inside {`LANE_DUAL, `LANE_QUAD})
                  ? lane_mode_in : `LANE_SINGLE; // RQ7
        if (s_r.fsm != st_idle) begin
            s_nxt.ph = period_end ? '0 : s_r.ph + (DIV_W+1)'(1);
        end
        case (s_r.fsm)
            st_idle: begin
                if (start_in) begin
                    s_nxt.fsm    = st_lead;
                    s_nxt.cs_n   = 1'b0; // RQ1 RQ17
                    s_nxt.busy   = 1'b1;
                    s_nxt.ph     = '0;
                    s_nxt.lead   = '0;
                    s_nxt.beat   = '0;
                    s_nxt.word   = '0;
                    s_nxt.rx_sh  = '0;
                    s_nxt.lanes  = eff_lanes;
                    s_nxt.pins   = pin_mode_in;
                    s_nxt.dly    = cs_to_clock_delay_field_in; // RQ6
                    s_nxt.div    = serial_clock_divide_ratio_in;
                    s_nxt.len_m1 = word_len_m1_in; // RQ3
                    s_nxt.cnt_m1 = word_count_m1_in; // RQ4
                    s_nxt.tx_sh  = tx_word_in << (LEN_W'(WORD_W - 1) - word_len_m1_in);
                    // First output bit appears with the select edge
                    s_nxt.d_o[`OUT_PIN] = s_nxt.tx_sh[WORD_W-1]; // RQ14
                    s_nxt.d_oe = (eff_lanes == `LANE_SINGLE && pin_mode_in != `PINS_THREE)
                               ? `OUT_PIN_OE : `PINS_OFF; // RQ15
                end
            end
            st_lead, st_shift: begin
                if (s_r.fsm == st_lead && period_end && !clk_per) begin
                    s_nxt.lead = s_r.lead + 2'h1; // RQ12
                end
                if (fe) begin
                    s_nxt.fsm   = st_shift;
                    s_nxt.tx_sh = s_r.tx_sh << 1;
                    // Frame-final bit is taken one period later, in the tail
                    if (!(last_beat && last_word)) begin
                        s_nxt.rx_sh = rx_next; // RQ11 RQ16
                    end
                    if (last_beat) begin
                        s_nxt.beat = '0;
                        if (last_word) begin
                            s_nxt.fsm  = st_tail;
                            s_nxt.tail = '0;
                        end else begin
                            word_done   = 1'b1;
                            s_nxt.word  = s_r.word + CNT_W'(1); // RQ4
                            s_nxt.tx_sh = tx_word_in << tx_align;
                        end
                    end else begin
                        s_nxt.beat = s_r.beat + LEN_W'(1);
                    end
                    s_nxt.d_o[`OUT_PIN] = s_nxt.tx_sh[WORD_W-1]; // RQ14
                end
            end
            st_tail: begin
                if (period_end) begin
                    if (s_r.tail != `TAIL_LAST) begin
                        s_nxt.rx_sh = rx_next; // RQ16
                        s_nxt.tail  = `TAIL_LAST;
                        word_done   = 1'b1;
                        frame_end   = 1'b1;
                    end else begin
                        s_nxt.fsm  = st_idle;
                        s_nxt.cs_n = 1'b1; // RQ13
                        s_nxt.d_oe = `PINS_OFF; // RQ15
                        s_nxt.d_o  = '0;
                        s_nxt.busy = 1'b0;
                    end
                end
            end
            default: begin
                s_nxt.fsm  = st_idle;
                s_nxt.cs_n = 1'b1;
                s_nxt.d_oe = `PINS_OFF;
            end
        endcase
        // Mode 0 clock: low then high within each clocked period
        n_clk_per  = (s_nxt.fsm == st_lead && s_nxt.lead == s_nxt.dly) || s_nxt.fsm == st_shift;
        s_nxt.sclk = n_clk_per && s_nxt.ph >= low_len(s_nxt.div); // RQ8 RQ10
        if (word_done) begin
            s_nxt.rx_word = s_nxt.rx_sh & ({WORD_W{1'b1}} >> tx_align);
        end
        s_nxt.word_valid = word_done;
        s_nxt.frame_done = frame_end;
        // A new event wins over a clear in the same cycle
        s_nxt.word_flag  = word_done | (s_r.word_flag & ~word_flag_clr_in); // RQ18 RQ5
        s_nxt.frame_flag = frame_end | (s_r.frame_flag & ~frame_flag_clr_in); // RQ18 RQ5
        s_nxt.irq = (s_nxt.word_flag & word_irq_en_in) | (s_nxt.frame_flag & frame_irq_en_in); // RQ18
    end
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            s_r      <= '0;
            s_r.fsm  <= st_idle;
            s_r.cs_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign sclk_out        = s_r.sclk;
    assign cs_n_out        = s_r.cs_n;
    assign data_pin_out    = s_r.d_o;
    assign data_pin_oe_out = s_r.d_oe;
    assign busy_out        = s_r.busy;
    assign rx_word_out     = s_r.rx_word;
    assign word_valid_out  = s_r.word_valid;
    assign frame_done_out  = s_r.frame_done;
    assign word_flag_out   = s_r.word_flag;
    assign frame_flag_out  = s_r.frame_flag;
    assign irq_out         = s_r.irq;

    // =================================================================
    // Checks
    logic [15:0] lead_cyc_r;
    always_ff @(posedge clk_sys_in) begin
        if (reset_in || s_r.fsm != st_lead) begin
            lead_cyc_r <= '0;
        end else begin
            lead_cyc_r <= lead_cyc_r + 16'h1;
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    chk_idle_pins: assert property (s_r.fsm == st_idle |-> s_r.cs_n && !s_r.sclk) // RQ1
        else $error("idle link not quiet");
    chk_clock_idle_low: assert property (s_r.cs_n |-> !s_r.sclk) // RQ10
        else $error("clock high with select inactive");
    chk_select_held: assert property (s_r.fsm == st_shift |-> !s_r.cs_n) // RQ17
        else $error("select dropped inside frame");
    chk_lead_length: assert property (s_r.fsm == st_lead && fe |->
        32'(lead_cyc_r) + 1 == (32'(s_r.dly) + 1) * (32'(per_m1(s_r.div)) + 1)) // RQ12
        else $error("select lead length wrong");
    chk_tail_release: assert property (frame_done_out |-> !cs_n_out [*2]) // RQ13
        else $error("select released too early");
    chk_tail_timing: assert property (s_r.fsm == st_tail && s_r.tail == `TAIL_LAST && period_end
        |=> s_r.cs_n && s_r.fsm == st_idle) // RQ13
        else $error("select not released after tail");
    chk_oe_in_frame: assert property (s_r.d_oe != '0 |-> !s_r.cs_n) // RQ15
        else $error("pin driven outside frame");
    chk_multi_lane_in: assert property (s_r.lanes != `LANE_SINGLE && !s_r.cs_n |-> s_r.d_oe == '0) // RQ2
        else $error("pin driven during multi-lane read");
    chk_flag_follows: assert property (word_valid_out |-> word_flag_out) // RQ5
        else $error("word flag not set");
    chk_irq_or: assert property (##1 irq_out == ((word_flag_out & $past(word_irq_en_in))
        | (frame_flag_out & $past(frame_irq_en_in)))) // RQ18
        else $error("interrupt not OR of enabled flags");
    chk_frame_word: assert property (frame_done_out |-> word_valid_out) // RQ16
        else $error("frame end without final word");
    cov_quad_frame: cover property (frame_done_out && s_r.lanes == `LANE_QUAD);
    cov_multi_word: cover property (word_valid_out && !frame_done_out);
    cov_set_over_clear: cover property (word_valid_out && $past(word_flag_clr_in));
endmodule

// file: dv/flash_target_model.sv
`timescale 1ns/1ps
// =====================================================================
// Serial flash: shifts read data out after each falling clock but the last
module flash_target_model (
    // Link pins
    input  wire logic         sclk_in,
    input  wire logic         cs_n_in,
    output logic [3:0]        data_out,
    // Read stream, lanes per beat and beats in the frame
    input  wire logic [127:0] pattern_in,
    input  wire logic [2:0]   lanes_in,
    input  wire logic [15:0]  beats_in
);
    int ptr;

    function automatic logic sb(int p);
        return pattern_in[127-(p%128)];
    endfunction

    function automatic logic [3:0] beat(int p);
        case (lanes_in)
            3'h4:    return {sb(p), sb(p+1), sb(p+2), sb(p+3)};
            3'h2:    return {sb(p), sb(p+1), sb(p), sb(p+1)};
            default: return {4{sb(p)}};
        endcase
    endfunction

    initial data_out = 4'h5;

    always @(negedge cs_n_in) begin
        ptr = 0;
        data_out = beat(0);
    end

    // Last beat is held until select rises, giving the late final sample
    always @(negedge sclk_in) begin
        #2;
        if (!cs_n_in && ptr / lanes_in + 1 < beats_in) begin
            ptr = ptr + lanes_in;
            data_out = beat(ptr);
        end
    end

    // Released lines carry no usable value
    always @(posedge cs_n_in) data_out = ~data_out;
endmodule

// file: dv/quad_spi_flash_read_master_bench.sv
`timescale 1ns/1ps
module quad_spi_flash_read_master_bench;
    localparam logic [127:0] PAT = 128'h9a3c_5e71_0f2d_b486_c1e9_7a35_2d80_f6b3;
    logic clk_sys_in = 0, reset_in = 1, start_in = 0;
    logic [1:0] lane_mode_in = 0, pin_mode_in = 0, cs_to_clock_delay_field_in = 0;
    logic [7:0] serial_clock_divide_ratio_in = 8'h03;
    logic [6:0] word_len_m1_in = 0;
    logic [11:0] word_count_m1_in = 0;
    logic [127:0] tx_word_in = 0, rx_word_out, pat = 0;
    logic word_irq_en_in = 0, frame_irq_en_in = 0, word_flag_clr_in = 0, frame_flag_clr_in = 0;
    logic [3:0] data_pin_in, data_pin_out, data_pin_oe_out, model_d;
    logic sclk_out, cs_n_out, busy_out, word_valid_out, frame_done_out, word_flag_out, frame_flag_out, irq_out;
    logic [2:0] mdl_k = 3'h1;
    logic [15:0] mdl_beats = 16'h0001;
    int mismatches = 0, cmp_count = 0;

    always #10 clk_sys_in = ~clk_sys_in;
    assign data_pin_in = (data_pin_oe_out & data_pin_out) | (~data_pin_oe_out & model_d);

    quad_spi_flash_read_master uut (
        .clk_sys_in, .reset_in, .start_in, .lane_mode_in, .pin_mode_in, .cs_to_clock_delay_field_in,
        .serial_clock_divide_ratio_in, .word_len_m1_in, .word_count_m1_in, .tx_word_in,
        .word_irq_en_in, .frame_irq_en_in, .word_flag_clr_in, .frame_flag_clr_in,
        .data_pin_in, .sclk_out, .cs_n_out, .data_pin_out, .data_pin_oe_out, .busy_out,
        .rx_word_out, .word_valid_out, .frame_done_out, .word_flag_out, .frame_flag_out, .irq_out
    );

    flash_target_model flash (
        .sclk_in(sclk_out), .cs_n_in(cs_n_out), .data_out(model_d),
        .pattern_in(pat), .lanes_in(mdl_k), .beats_in(mdl_beats)
    );

    // =================================================================
    // Shared tasks
    task automatic finish_test();
        if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    task automatic run_frame(input logic [1:0] lm, pm, dd, input logic [7:0] nn, input int ln, wc,
                             input logic [127:0] tx);
        int k, b, p, c, nf, wv, f, hi, s;
        logic ps;
        logic [127:0] ex;
        k = (pm == 2'h2 && lm == 2'h1) ? 2 : (pm == 2'h2 && lm == 2'h2) ? 4 : 1;
        b = (ln + k - 1) / k;
        p = (nn == 0) ? 2 : nn + 1;
        mdl_k = 3'(k);
        mdl_beats = 16'(wc * b);
        pat = ~tx;
        lane_mode_in = lm;
        pin_mode_in = pm;
        cs_to_clock_delay_field_in = dd;
        serial_clock_divide_ratio_in = nn;
        word_len_m1_in = 7'(ln - 1);
        word_count_m1_in = 12'(wc - 1);
        tx_word_in = tx;
        start_in = 1;
        tick(1);
        start_in = 0;
        tick(1);
        c = 2; nf = 0; wv = 0; f = 0; hi = 0;
        check("busy", {busy_out, cs_n_out}, 2'b10);
        if (k == 1 && pm != 2'h0) check("d1_first", {data_pin_oe_out, data_pin_out[1]}, {4'h2, tx[ln-1]});
        else check("oe_off", data_pin_oe_out, 0);
        while (cs_n_out === 1'b0) begin
            ps = sclk_out;
            tick(1);
            c++;
            start_in = (c == 3);
            if (sclk_out) hi++;
            if (ps && !sclk_out) begin
                nf++;
                f = c;
                if (nf == 1) check("first_fall", c, 1 + (dd + 1) * p);
                check("high_len", hi, p / 2);
                hi = 0;
            end
            if (!ps && sclk_out && k == 1 && pm != 2'h0) check("d1_bit", data_pin_out[1], tx[ln-1-(nf%ln)]);
            if (word_valid_out === 1'b1) begin
                s = wv * b * k + b * k - ln;
                ex = 0;
                for (int j = 0; j < ln; j++) ex[ln-1-j] = pat[127-((s+j)%128)];
                wv++;
                check("rx_word", rx_word_out, ex);
                check("frame_done", frame_done_out, wv == wc);
                if (wv == wc) check("last_sample", c, f + p);
            end
            if (c > 20000) begin
                mismatches++;
                finish_test();
            end
        end
        check("cs_release", c, f + 2 * p);
        check("falls", nf, wc * b);
        check("idle", {busy_out, sclk_out}, 0);
    endtask

    // =================================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_sys_in);
        #1 reset_in = 0;
        tick(1);
        check("reset", {cs_n_out, sclk_out, busy_out, data_pin_oe_out, irq_out}, 8'h80);
        word_irq_en_in = 1;
        run_frame(2'h0, 2'h1, 2'h0, 8'h03, 8, 2, PAT);
        tick(2);
        check("no_restart", cs_n_out, 1);
        check("flags", {word_flag_out, frame_flag_out, irq_out}, 3'b111);
        word_flag_clr_in = 1;
        tick(1);
        word_flag_clr_in = 0;
        tick(2);
        check("word_clr", {word_flag_out, frame_flag_out, irq_out}, 3'b010);
        frame_irq_en_in = 1;
        tick(2);
        check("frame_irq", irq_out, 1);
        frame_flag_clr_in = 1;
        tick(1);
        frame_flag_clr_in = 0;
        tick(2);
        check("frame_clr", {frame_flag_out, irq_out}, 0);
        run_frame(2'h1, 2'h2, 2'h3, 8'h05, 7, 1, ~PAT);
        run_frame(2'h2, 2'h2, 2'h1, 8'h04, 128, 3, PAT);
        run_frame(2'h0, 2'h0, 2'h2, 8'h03, 1, 1, PAT);
        run_frame(2'h3, 2'h2, 2'h0, 8'h07, 5, 2, ~PAT);
        run_frame(2'h2, 2'h1, 2'h0, 8'h03, 1, 4096, PAT);
        finish_test();
    end
endmodule
